/* verilog/cch_conflict_handler.sv */
// Purpose: conflict handling and deadlock avoidance for the coherent write cache
// Assumes: all inputs synchronous to mclk, completions carry a valid tracker id
// Notes: completions and promotions have no ready; they are always absorbed
//
// Behaviour
// - a stalled conflicting request stops only a second request to its line, and reads after that conflict.
// - one stalled request per active line; a second conflict blocks all reads.
// - promotions are never blocked and never raise a conflict.
// - snoops hitting request phase get conflict response; ack phase buffers them.
// - plain and forwarding completions clear buffered snoops; data completions leave them set.
// - current-copy read with forwarding completion: invalid to home, ends invalid.
// - code read with forwarding completion: invalid to home, line dropped invalid.
// - ownership read not at queue head: invalid response, line invalid.
// - ownership read at head: writeback to home, or modified data forwarded.
// - exclusive writeback with forwarding completion sends invalid to home.
// - completions always absorbed; an entry is reserved before each request.
// - peer-to-peer non-posted requests can fill the tracker only through a conflict replay.
// - reads keep fair access to tracker entries.
// - pci completions always pass deferred requests.
// - inbound responses are never blocked by the home channel.
// - snoop hitting a line under promotion at the queue head stalls until the promotion arrives.
// - snoop hitting an ownership read under promotion off the queue head revokes ownership, reissues ownership read.

`timescale 1ns/100ps

module cch_conflict_handler #(
  parameter bit FWD_OWN_DIRECT = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic lreq_valid,
  input wire cch_pkg::cch_lreq_s lreq,
  output logic lreq_ready,
  input wire logic snp_valid,
  input wire cch_pkg::cch_snp_s snp,
  output logic snp_ready,
  input wire logic cmp_valid,
  input wire cch_pkg::cch_cmp_s cmp,
  input wire logic ackc_valid,
  input wire logic [cch_pkg::CCH_ID_W-1:0] ackc_id,
  input wire logic ordq_head_valid,
  input wire logic [cch_pkg::CCH_ID_W-1:0] ordq_head_id,
  input wire logic prom_valid,
  input wire logic [cch_pkg::CCH_ID_W-1:0] prom_id,
  input wire logic pci_cmp_valid,
  input wire logic pci_dreq_valid,
  input wire logic pci_out_ready,
  output logic pci_cmp_take,
  output logic pci_dreq_take,
  output logic iss_valid,
  output cch_pkg::cch_iss_s iss,
  output logic srsp_valid,
  output cch_pkg::cch_srsp_s srsp,
  output logic hrsp_valid,
  output cch_pkg::cch_hrsp_s hrsp,
  output logic line_inv_valid,
  output logic [cch_pkg::CCH_LINE_W-1:0] line_inv,
  output logic reads_blocked
);
  import cch_pkg::*;

  // ------------------------------------------------------------------
  // tracker state
  // ------------------------------------------------------------------
  cch_phase_e phase_reg [CCH_ENTRIES];
  logic [CCH_LINE_W-1:0] line_reg [CCH_ENTRIES];
  cch_lkind_e kind_reg [CCH_ENTRIES];
  logic [CCH_ENTRIES-1:0] byp_v_reg;
  cch_lreq_s byp_reg [CCH_ENTRIES];
  logic [CCH_ENTRIES-1:0] snp_buf_reg;
  logic [CCH_ENTRIES-1:0] reiss_reg;
  logic blk_reg;

  logic [CCH_ENTRIES-1:0] lhit;
  logic [CCH_ENTRIES-1:0] shit;
  logic [CCH_ENTRIES-1:0] free_v;
  logic [CCH_ENTRIES-1:0] pend_v;
  logic [CCH_ENTRIES-1:0] coh_v;
  logic [CCH_ID_W-1:0] lidx;
  logic [CCH_ID_W-1:0] sidx;
  logic [CCH_ID_W-1:0] fidx;
  logic [CCH_ID_W-1:0] pidx;
  logic [2:0] free_cnt;
  logic [2:0] p2p_cnt;
  logic is_rd;
  logic pool_ok;
  logic lhit_any;
  logic shit_any;
  logic pend_any;
  logic s_at_head;
  logic take_new;
  logic take_byp;
  logic second_cnflt;

  // ------------------------------------------------------------------
  // per-entry compare
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < CCH_ENTRIES; gi++) begin : g_cmp
      assign coh_v[gi] = (kind_reg[gi] == CCH_LK_RD_CUR) || (kind_reg[gi] == CCH_LK_RD_CODE) ||
                         (kind_reg[gi] == CCH_LK_OWN_RD) || (kind_reg[gi] == CCH_LK_EXCL_WB);
      assign lhit[gi] = (phase_reg[gi] != CCH_PH_IDLE) && (line_reg[gi] == lreq.line);
      assign shit[gi] = (phase_reg[gi] != CCH_PH_IDLE) && coh_v[gi] &&
                        (line_reg[gi] == snp.line);
      assign free_v[gi] = (phase_reg[gi] == CCH_PH_IDLE) && !byp_v_reg[gi];
      assign pend_v[gi] = ((phase_reg[gi] == CCH_PH_IDLE) && byp_v_reg[gi]) || reiss_reg[gi];
    end
  endgenerate

  always_comb begin
    lidx = '0;
    sidx = '0;
    fidx = '0;
    pidx = '0;
    free_cnt = '0;
    p2p_cnt = '0;
    for (int i = CCH_ENTRIES - 1; i >= 0; i--) begin
      if (lhit[i]) begin
        lidx = CCH_ID_W'(i);
      end
      if (shit[i]) begin
        sidx = CCH_ID_W'(i);
      end
      if (free_v[i]) begin
        fidx = CCH_ID_W'(i);
      end
      if (pend_v[i]) begin
        pidx = CCH_ID_W'(i);
      end
      free_cnt = free_cnt + {2'h0, free_v[i]};
      p2p_cnt = p2p_cnt + {2'h0, (phase_reg[i] != CCH_PH_IDLE) && (kind_reg[i] == CCH_LK_P2P_NP)};
    end
  end

  assign lhit_any = |lhit;
  assign shit_any = |shit;
  assign pend_any = |pend_v;
  assign is_rd = (lreq.kind == CCH_LK_RD_CUR) || (lreq.kind == CCH_LK_RD_CODE) ||
                 (lreq.kind == CCH_LK_OWN_RD);

  // ------------------------------------------------------------------
  // local request admission
  // ------------------------------------------------------------------
  // a free entry is the completion slot, so nothing issues without one
  always_comb begin
    if (is_rd) begin
      pool_ok = free_cnt != 3'h0;
    end else if (lreq.kind == CCH_LK_P2P_NP) begin
      pool_ok = (free_cnt > CCH_RD_RESERVE) && (p2p_cnt < CCH_P2P_MAX);
    end else begin
      pool_ok = free_cnt > CCH_RD_RESERVE;
    end
  end

  // pending replays own the issue port for one cycle; this costs a bubble, not a stall
  assign lreq_ready = !pend_any && !(blk_reg && is_rd) &&
                      (lhit_any ? !byp_v_reg[lidx] : pool_ok);
  assign take_new = lreq_valid && lreq_ready && !lhit_any;
  assign take_byp = lreq_valid && lreq_ready && lhit_any;
  assign second_cnflt = lreq_valid && lhit_any && byp_v_reg[lidx] && !pend_any;

  // ------------------------------------------------------------------
  // snoop decision
  // ------------------------------------------------------------------
  assign s_at_head = ordq_head_valid && (ordq_head_id == sidx);
  assign snp_ready = !(shit_any && (phase_reg[sidx] == CCH_PH_OWN) && s_at_head);

  // ------------------------------------------------------------------
  // pci ordered domain
  // ------------------------------------------------------------------
  assign pci_cmp_take = pci_cmp_valid && pci_out_ready;
  assign pci_dreq_take = pci_dreq_valid && pci_out_ready && !pci_cmp_valid;

  // ------------------------------------------------------------------
  // second-conflict block
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      blk_reg <= 1'b0;
    end else if (second_cnflt) begin
      blk_reg <= 1'b1;
    end else if (pend_any && !reiss_reg[pidx]) begin
      blk_reg <= 1'b0;
    end
  end

  assign reads_blocked = blk_reg;

  // ------------------------------------------------------------------
  // tracker entries
  // ------------------------------------------------------------------
  // order within the cycle: replay, new request, snoop, completion, promotion;
  // later events win because they come from the far side and cannot wait
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CCH_ENTRIES; i++) begin
        phase_reg[i] <= CCH_PH_IDLE;
        line_reg[i] <= '0;
        kind_reg[i] <= CCH_LK_POSTED;
        byp_reg[i] <= '0;
      end
      byp_v_reg <= '0;
      snp_buf_reg <= '0;
      reiss_reg <= '0;
    end else begin
      if (pend_any) begin
        if (reiss_reg[pidx]) begin
          reiss_reg[pidx] <= 1'b0;
        end else begin
          phase_reg[pidx] <= CCH_PH_REQ;
          line_reg[pidx] <= byp_reg[pidx].line;
          kind_reg[pidx] <= byp_reg[pidx].kind;
          byp_v_reg[pidx] <= 1'b0;
        end
      end
      if (take_new) begin
        phase_reg[fidx] <= CCH_PH_REQ;
        line_reg[fidx] <= lreq.line;
        kind_reg[fidx] <= lreq.kind;
      end
      if (take_byp) begin
        byp_v_reg[lidx] <= 1'b1;
        byp_reg[lidx] <= lreq;
      end
      if (snp_valid && snp_ready && shit_any) begin
        if (phase_reg[sidx] == CCH_PH_ACK) begin
          snp_buf_reg[sidx] <= 1'b1;
        end else if (phase_reg[sidx] == CCH_PH_OWN) begin
          phase_reg[sidx] <= CCH_PH_REQ;
          reiss_reg[sidx] <= 1'b1;
        end
      end
      if (ackc_valid && (phase_reg[ackc_id] == CCH_PH_REQ)) begin
        phase_reg[ackc_id] <= CCH_PH_ACK;
      end
      if (cmp_valid && (phase_reg[cmp.id] != CCH_PH_IDLE)) begin
        if (cmp.kind != CCH_CK_DATA) begin
          snp_buf_reg[cmp.id] <= 1'b0;
        end
        if ((cmp.kind == CCH_CK_DATA || cmp.kind == CCH_CK_PLAIN) &&
            (kind_reg[cmp.id] == CCH_LK_OWN_RD)) begin
          phase_reg[cmp.id] <= CCH_PH_OWN;
        end else begin
          phase_reg[cmp.id] <= CCH_PH_IDLE;
        end
      end
      if (prom_valid && (phase_reg[prom_id] == CCH_PH_OWN)) begin
        phase_reg[prom_id] <= CCH_PH_IDLE;
      end
    end
  end

  // ------------------------------------------------------------------
  // request issue
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      iss_valid <= 1'b0;
      iss <= '0;
    end else begin
      iss_valid <= pend_any || take_new;
      if (pend_any) begin
        iss.id <= pidx;
        iss.line <= reiss_reg[pidx] ? line_reg[pidx] : byp_reg[pidx].line;
        iss.kind <= reiss_reg[pidx] ? CCH_LK_OWN_RD : byp_reg[pidx].kind;
      end else if (take_new) begin
        iss.id <= fidx;
        iss.line <= lreq.line;
        iss.kind <= lreq.kind;
      end
    end
  end

  // ------------------------------------------------------------------
  // snoop responses
  // ------------------------------------------------------------------
  // remote snoops are answered the next cycle unless buffered or under promotion at the queue head
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      srsp_valid <= 1'b0;
      srsp <= '0;
    end else begin
      srsp_valid <= snp_valid && snp_ready && !(shit_any && phase_reg[sidx] == CCH_PH_ACK);
      srsp.line <= snp.line;
      if (shit_any && (phase_reg[sidx] == CCH_PH_REQ)) begin
        srsp.kind <= CCH_SR_CONFLICT;
      end else begin
        srsp.kind <= CCH_SR_INVALID;
      end
    end
  end

  // ------------------------------------------------------------------
  // forwarding completion answers
  // ------------------------------------------------------------------
  logic fwd_hit;
  logic c_at_head;
  assign fwd_hit = cmp_valid && (phase_reg[cmp.id] != CCH_PH_IDLE) &&
                   (cmp.kind != CCH_CK_DATA) && (cmp.kind != CCH_CK_PLAIN);
  assign c_at_head = ordq_head_valid && (ordq_head_id == cmp.id);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hrsp_valid <= 1'b0;
      hrsp <= '0;
      line_inv_valid <= 1'b0;
      line_inv <= '0;
    end else begin
      hrsp_valid <= fwd_hit;
      line_inv_valid <= fwd_hit && (kind_reg[cmp.id] != CCH_LK_EXCL_WB);
      line_inv <= line_reg[cmp.id];
      hrsp.id <= cmp.id;
      hrsp.kind <= CCH_HR_INVALID;
      hrsp.with_wb_data <= 1'b0;
      hrsp.req_mod_data <= 1'b0;
      if ((kind_reg[cmp.id] == CCH_LK_OWN_RD) && c_at_head) begin
        if (FWD_OWN_DIRECT && (cmp.kind == CCH_CK_FWD_OWN)) begin
          hrsp.kind <= CCH_HR_FWD_INVALID;
          hrsp.req_mod_data <= 1'b1;
        end else begin
          hrsp.kind <= CCH_HR_INVALID_WB;
          hrsp.with_wb_data <= 1'b1;
        end
      end
    end
  end

endmodule : cch_conflict_handler

/* shared/cch_pkg.sv */
// Purpose: shared types and constants of the coherent conflict handler
// Assumes: one core clock, tracker ids index the outstanding request tracker
// Notes: kinds are plain encodings, phases are one-hot

package cch_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int unsigned CCH_ENTRIES = 4;
  localparam int unsigned CCH_ID_W = 2;
  localparam int unsigned CCH_LINE_W = 34;
  localparam logic [2:0] CCH_CNT_ENTRIES = 3'h4;
  // non-conflicting p2p non-posted requests are refused once this many entries hold them
  localparam logic [2:0] CCH_P2P_MAX = 3'h3;
  // non-read requests leave this many entries for reads
  localparam logic [2:0] CCH_RD_RESERVE = 3'h1;

  // ------------------------------------------------------------------
  // encodings
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CCH_LK_RD_CUR = 3'h0,
    CCH_LK_RD_CODE = 3'h1,
    CCH_LK_OWN_RD = 3'h2,
    CCH_LK_EXCL_WB = 3'h3,
    CCH_LK_P2P_NP = 3'h4,
    CCH_LK_POSTED = 3'h5
  } cch_lkind_e;

  typedef enum logic [1:0] {
    CCH_SK_CODE = 2'h0,
    CCH_SK_DATA = 2'h1,
    CCH_SK_INV_ITOE = 2'h2,
    CCH_SK_INV_ANY = 2'h3
  } cch_skind_e;

  typedef enum logic [2:0] {
    CCH_CK_DATA = 3'h0,
    CCH_CK_PLAIN = 3'h1,
    CCH_CK_FWD_CODE = 3'h2,
    CCH_CK_FWD_INV = 3'h3,
    CCH_CK_FWD_OWN = 3'h4
  } cch_ckind_e;

  typedef enum logic [1:0] {
    CCH_SR_INVALID = 2'h0,
    CCH_SR_CONFLICT = 2'h1
  } cch_srsp_e;

  typedef enum logic [1:0] {
    CCH_HR_INVALID = 2'h0,
    CCH_HR_INVALID_WB = 2'h1,
    CCH_HR_FWD_INVALID = 2'h2
  } cch_hrsp_e;

  typedef enum logic [3:0] {
    CCH_PH_IDLE = 4'b0001,
    CCH_PH_REQ = 4'b0010,
    CCH_PH_ACK = 4'b0100,
    CCH_PH_OWN = 4'b1000
  } cch_phase_e;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [CCH_LINE_W-1:0] line;
    cch_lkind_e kind;
  } cch_lreq_s;

  typedef struct packed {
    logic [CCH_LINE_W-1:0] line;
    cch_skind_e kind;
  } cch_snp_s;

  typedef struct packed {
    logic [CCH_ID_W-1:0] id;
    cch_ckind_e kind;
  } cch_cmp_s;

  typedef struct packed {
    logic [CCH_ID_W-1:0] id;
    logic [CCH_LINE_W-1:0] line;
    cch_lkind_e kind;
  } cch_iss_s;

  typedef struct packed {
    logic [CCH_LINE_W-1:0] line;
    cch_srsp_e kind;
  } cch_srsp_s;

  typedef struct packed {
    logic [CCH_ID_W-1:0] id;
    cch_hrsp_e kind;
    logic with_wb_data;
    logic req_mod_data;
  } cch_hrsp_s;

endpackage : cch_pkg

/* verification/cch_home_model.sv */
// Purpose: home agent model answering issued requests with completions
// Assumes: ids come from the handler's issue port
// Notes: bench commands data, plain or forwarding completions; auto mode returns data after lat
`timescale 1ns/100ps

module cch_home_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic iss_valid,
  input wire cch_pkg::cch_iss_s iss,
  input wire logic auto_en,
  input wire logic [3:0] lat,
  input wire logic cmd_go,
  input wire cch_pkg::cch_cmp_s cmd,
  output logic cmp_valid,
  output cch_pkg::cch_cmp_s cmp
);
  import cch_pkg::*;
  logic [3:0] pend_reg;
  logic [3:0] age_reg [4];
  int pick;

  // ----------------------------------------------------------------
  // completions
  // ----------------------------------------------------------------
  always_comb begin
    pick = -1;
    for (int i = 3; i >= 0; i--) begin
      if (pend_reg[i] && age_reg[i] >= lat) pick = i;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_valid <= 1'b0;
      cmp <= '0;
      pend_reg <= '0;
      age_reg <= '{default: 4'h0};
    end else begin
      cmp_valid <= 1'b0;
      // idle lines toggle so a stale id is never trusted
      cmp <= ~cmp;
      for (int i = 0; i < 4; i++) begin
        if (age_reg[i] != 4'hf) age_reg[i] <= age_reg[i] + 4'h1;
      end
      if (iss_valid) begin
        pend_reg[iss.id] <= 1'b1;
        age_reg[iss.id] <= 4'h0;
      end
      if (cmd_go) begin
        cmp_valid <= 1'b1;
        cmp <= cmd;
        pend_reg[cmd.id] <= 1'b0;
      end else if (auto_en && pick >= 0) begin
        cmp_valid <= 1'b1;
        cmp <= '{id: pick[1:0], kind: CCH_CK_DATA};
        pend_reg[pick[1:0]] <= 1'b0;
      end
    end
  end
endmodule : cch_home_model

/* verification/cch_conflict_handler_properties.sv */
// Purpose: port-level checks of the conflict handler
// Assumes: answers are registered at the edge that takes their cause
// Notes: helper flops hold last cycle's causes
`timescale 1ns/100ps

module cch_conflict_handler_properties #(
  parameter bit FWD_OWN_DIRECT = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic lreq_valid,
  input wire cch_pkg::cch_lreq_s lreq,
  input wire logic lreq_ready,
  input wire logic snp_valid,
  input wire cch_pkg::cch_snp_s snp,
  input wire logic snp_ready,
  input wire logic cmp_valid,
  input wire cch_pkg::cch_cmp_s cmp,
  input wire logic ordq_head_valid,
  input wire logic [cch_pkg::CCH_ID_W-1:0] ordq_head_id,
  input wire logic pci_cmp_valid,
  input wire logic pci_out_ready,
  input wire logic pci_cmp_take,
  input wire logic pci_dreq_take,
  input wire logic srsp_valid,
  input wire cch_pkg::cch_srsp_s srsp,
  input wire logic hrsp_valid,
  input wire cch_pkg::cch_hrsp_s hrsp,
  input wire logic line_inv_valid,
  input wire logic reads_blocked
);
  import cch_pkg::*;
  logic snp_tk_reg, cmp_v_reg, head_reg, lreq_ref_reg;
  logic [CCH_LINE_W-1:0] snp_line_reg;
  cch_cmp_s cmp_reg;

  // ----------------------------------------------------------------
  // last-cycle causes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      snp_tk_reg <= 1'b0;
      snp_line_reg <= '0;
      cmp_v_reg <= 1'b0;
      cmp_reg <= '0;
      head_reg <= 1'b0;
      lreq_ref_reg <= 1'b0;
    end else begin
      snp_tk_reg <= snp_valid && snp_ready;
      snp_line_reg <= snp.line;
      cmp_v_reg <= cmp_valid;
      cmp_reg <= cmp;
      head_reg <= ordq_head_valid && ordq_head_id == cmp.id;
      lreq_ref_reg <= lreq_valid && !lreq_ready;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_pci_cmp_first: assert property (pci_cmp_valid |->
    !pci_dreq_take && pci_cmp_take == pci_out_ready) else $error("deferred passed completion");
  a_srsp_cause: assert property (srsp_valid |->
    snp_tk_reg && srsp.line == snp_line_reg) else $error("snoop answer without snoop");
  a_reads_refused: assert property (reads_blocked &&
    lreq.kind inside {CCH_LK_RD_CUR, CCH_LK_RD_CODE, CCH_LK_OWN_RD} |-> !lreq_ready)
    else $error("read taken while blocked");
  a_block_cause: assert property ($rose(reads_blocked) |-> lreq_ref_reg)
    else $error("block without refused request");
  a_snoop_stall: assert property (snp_valid && !snp_ready |-> ordq_head_valid)
    else $error("snoop stalled without promotion");
  a_hrsp_cause: assert property (hrsp_valid |-> cmp_v_reg && hrsp.id == cmp_reg.id &&
    cmp_reg.kind inside {CCH_CK_FWD_CODE, CCH_CK_FWD_INV, CCH_CK_FWD_OWN})
    else $error("home answer without forward");
  a_hrsp_off_head: assert property (hrsp_valid && !head_reg |->
    hrsp.kind == CCH_HR_INVALID && !hrsp.with_wb_data && !hrsp.req_mod_data)
    else $error("off-head answer not plain invalid");
  a_wb_carries: assert property (hrsp_valid && hrsp.kind == CCH_HR_INVALID_WB |->
    hrsp.with_wb_data && !hrsp.req_mod_data) else $error("writeback answer lacks data");
  a_own_forward: assert property (hrsp_valid && hrsp.kind == CCH_HR_FWD_INVALID |->
    hrsp.req_mod_data && FWD_OWN_DIRECT && cmp_reg.kind == CCH_CK_FWD_OWN)
    else $error("forwarded answer wrong");
  a_inv_with_rsp: assert property (line_inv_valid |-> hrsp_valid)
    else $error("line dropped without answer");

  c_conflict: cover property (srsp_valid && srsp.kind == CCH_SR_CONFLICT);
  c_fwd_own: cover property (hrsp_valid && hrsp.kind == CCH_HR_FWD_INVALID);
  c_block: cover property ($rose(reads_blocked));
endmodule : cch_conflict_handler_properties

/* verification/tb_top.sv */
// Purpose: self-checking bench of the conflict handler
// Assumes: inputs change at the falling edge, outputs read there
// Notes: forwarding table runs as rows, stall cases by hand
`timescale 1ns/100ps

module tb_top;
  import cch_pkg::*;
  typedef struct packed {
    cch_lkind_e k;
    cch_ckind_e c;
    logic hd;
    cch_hrsp_e h;
    logic inv, wb, md;
  } cch_row_s;
  logic mclk, rst_b, lreq_valid, snp_valid, cmp_valid, ackc_valid, ordq_head_valid, prom_valid;
  logic pci_cmp_valid, pci_dreq_valid, pci_out_ready, auto_en, cmd_go, ok;
  logic lreq_ready, snp_ready, pci_cmp_take, pci_dreq_take, iss_valid, srsp_valid;
  logic hrsp_valid, line_inv_valid, reads_blocked, s_iss, s_srsp, s_hrsp, s_inv;
  logic [1:0] ackc_id, ordq_head_id, prom_id;
  logic [3:0] lat;
  logic [33:0] line_inv, g_inv, l;
  cch_lreq_s lreq;
  cch_snp_s snp;
  cch_cmp_s cmp, cmd;
  cch_iss_s iss, g_iss;
  cch_srsp_s srsp, g_srsp;
  cch_hrsp_s hrsp, g_hrsp;
  int n_mismatch = 0;
  int compares = 0;
  cch_row_s rows [7] = '{
    '{CCH_LK_RD_CUR, CCH_CK_FWD_CODE, 1'b0, CCH_HR_INVALID, 1'b1, 1'b0, 1'b0},
    '{CCH_LK_RD_CODE, CCH_CK_FWD_INV, 1'b0, CCH_HR_INVALID, 1'b1, 1'b0, 1'b0},
    '{CCH_LK_OWN_RD, CCH_CK_FWD_OWN, 1'b0, CCH_HR_INVALID, 1'b1, 1'b0, 1'b0},
    '{CCH_LK_OWN_RD, CCH_CK_FWD_CODE, 1'b1, CCH_HR_INVALID_WB, 1'b1, 1'b1, 1'b0},
    '{CCH_LK_OWN_RD, CCH_CK_FWD_INV, 1'b1, CCH_HR_INVALID_WB, 1'b1, 1'b1, 1'b0},
    '{CCH_LK_OWN_RD, CCH_CK_FWD_OWN, 1'b1, CCH_HR_FWD_INVALID, 1'b1, 1'b0, 1'b1},
    '{CCH_LK_EXCL_WB, CCH_CK_FWD_CODE, 1'b0, CCH_HR_INVALID, 1'b0, 1'b0, 1'b0}};

  cch_conflict_handler dut (.*);
  cch_home_model home (.*);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task req(input cch_lkind_e k, input logic [33:0] a);
    @(negedge mclk);
    lreq_valid = 1'b1;
    lreq = '{line: a, kind: k};
    #1 ok = lreq_ready;
    @(negedge mclk);
    lreq_valid = 1'b0;
    lreq = ~lreq;
  endtask : req

  task snoop(input cch_skind_e k, input logic [33:0] a);
    @(negedge mclk);
    snp_valid = 1'b1;
    snp = '{line: a, kind: k};
    #1 ok = snp_ready;
    @(negedge mclk);
    snp_valid = 1'b0;
    snp = ~snp;
  endtask : snoop

  task ack(input logic [1:0] i);
    @(negedge mclk);
    ackc_valid = 1'b1;
    ackc_id = i;
    @(negedge mclk);
    ackc_valid = 1'b0;
  endtask : ack

  task prom(input logic [1:0] i);
    @(negedge mclk);
    prom_valid = 1'b1;
    prom_id = i;
    @(negedge mclk);
    prom_valid = 1'b0;
  endtask : prom

  task fwd(input logic [1:0] i, input cch_ckind_e k);
    @(negedge mclk);
    cmd_go = 1'b1;
    cmd = '{id: i, kind: k};
    @(negedge mclk);
    cmd_go = 1'b0;
  endtask : fwd

  // answers are one-cycle pulses, so each falling edge is sampled
  task watch(input int n);
    {s_iss, s_srsp, s_hrsp, s_inv, g_inv} = '0;
    repeat (n) begin
      if (iss_valid) {s_iss, g_iss} = {1'b1, iss};
      if (srsp_valid) {s_srsp, g_srsp} = {1'b1, srsp};
      if (hrsp_valid) {s_hrsp, g_hrsp} = {1'b1, hrsp};
      if (line_inv_valid) {s_inv, g_inv} = {1'b1, line_inv};
      @(negedge mclk);
    end
  endtask : watch

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {lreq_valid, snp_valid, ackc_valid, ordq_head_valid, prom_valid, cmd_go, auto_en} = '0;
    {pci_cmp_valid, pci_dreq_valid, pci_out_ready, ackc_id, ordq_head_id, prom_id} = '0;
    {lreq, snp, cmd} = '0;
    lat = 4'h6;
    rst_b = 1'b0;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    chk({iss_valid, srsp_valid, hrsp_valid, line_inv_valid, reads_blocked}, 64'h0);
    for (int i = 0; i < 8; i++) begin
      @(negedge mclk) {pci_out_ready, pci_dreq_valid, pci_cmp_valid} = i[2:0];
      #1 chk({pci_cmp_take, pci_dreq_take}, {i[0] & i[2], i[1] & !i[0] & i[2]});
    end
    for (int r = 0; r < 7; r++) begin
      l = 34'h100 + r;
      req(rows[r].k, l);
      watch(3);
      chk({s_iss, g_iss}, {1'b1, 2'h0, l, rows[r].k});
      snoop(cch_skind_e'(r[1:0]), l);
      watch(2);
      chk({s_srsp, g_srsp}, {1'b1, l, CCH_SR_CONFLICT});
      ack(2'h0);
      snoop(cch_skind_e'(r[1:0]), l);
      watch(3);
      chk(s_srsp, 1'b0);
      ordq_head_valid = rows[r].hd;
      fwd(2'h0, rows[r].c);
      watch(3);
      chk({s_hrsp, g_hrsp},
          {1'b1, 2'h0, rows[r].h, rows[r].wb, rows[r].md});
      chk({s_inv, g_inv},
          {rows[r].inv, rows[r].inv ? l : 34'h0});
      ordq_head_valid = 1'b0;
      snoop(CCH_SK_DATA, l);
      watch(2);
      chk({s_srsp, g_srsp.kind}, {1'b1, CCH_SR_INVALID});
    end
    req(CCH_LK_RD_CUR, 34'h200);
    req(CCH_LK_OWN_RD, 34'h200);
    watch(3);
    chk({ok, s_iss}, 2'b10);
    req(CCH_LK_RD_CODE, 34'h200);
    chk({ok, reads_blocked}, 2'b01);
    req(CCH_LK_POSTED, 34'h300);
    watch(2);
    chk({ok, s_iss, g_iss.id}, {2'b11, 2'h1});
    fwd(2'h0, CCH_CK_PLAIN);
    watch(5);
    chk({s_iss, g_iss.line, g_iss.kind, reads_blocked},
        {1'b1, 34'h200, CCH_LK_OWN_RD, 1'b0});
    fwd(2'h1, CCH_CK_DATA);
    fwd(2'h0, CCH_CK_DATA);
    prom(2'h0);
    for (int i = 0; i < 3; i++) begin
      req(CCH_LK_P2P_NP, 34'h400 + i);
      chk(ok, 1'b1);
    end
    req(CCH_LK_P2P_NP, 34'h410);
    chk(ok, 1'b0);
    req(CCH_LK_RD_CUR, 34'h420);
    chk(ok, 1'b1);
    auto_en = 1'b1;
    repeat (20) @(negedge mclk);
    auto_en = 1'b0;
    req(CCH_LK_POSTED, 34'h430);
    chk(ok, 1'b1);
    fwd(2'h0, CCH_CK_DATA);
    req(CCH_LK_OWN_RD, 34'h500);
    fwd(2'h0, CCH_CK_DATA);
    ordq_head_valid = 1'b1;
    snoop(CCH_SK_DATA, 34'h500);
    chk(ok, 1'b0);
    prom(2'h0);
    ordq_head_valid = 1'b0;
    snoop(CCH_SK_DATA, 34'h500);
    watch(2);
    chk({ok, s_srsp, g_srsp.kind}, {2'b11, CCH_SR_INVALID});
    req(CCH_LK_OWN_RD, 34'h600);
    fwd(2'h0, CCH_CK_DATA);
    snoop(CCH_SK_INV_ANY, 34'h600);
    watch(4);
    chk({s_srsp, g_srsp.kind, s_iss, g_iss.kind, g_iss.id},
        {1'b1, CCH_SR_INVALID, 1'b1, CCH_LK_OWN_RD, 2'h0});
    snoop(CCH_SK_CODE, 34'h601);
    watch(2);
    chk({s_srsp, g_srsp.kind}, {1'b1, CCH_SR_INVALID});
    give_verdict();
  end
endmodule : tb_top

bind cch_conflict_handler cch_conflict_handler_properties #(
  .FWD_OWN_DIRECT(FWD_OWN_DIRECT)
) u_props (.*);
